// ### rtl/tec_cfg.svh
// Constants for the paired timer/event counter block.
// Assumes a 32-bit classic Wishbone slave, register index = byte addr / 4.
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH

// Register indices
`define TEC_IDX_CNT0_HI   6'h0C
`define TEC_IDX_CNT0_LO   6'h0D
`define TEC_IDX_CNT0_CTL  6'h0E
`define TEC_IDX_CNT1_HI   6'h0F
`define TEC_IDX_CNT1_LO   6'h10
`define TEC_IDX_CNT1_CTL  6'h11
`define TEC_IDX_IRQ       6'h12
`define TEC_IDX_PORTA     6'h13

// Control field positions
`define TEC_BIT_PSC_LO    0
`define TEC_BIT_PSC_HI    2
`define TEC_BIT_EDGE      3
`define TEC_BIT_RUN       4
`define TEC_BIT_SRC       5
`define TEC_BIT_MODE_LO   6
`define TEC_BIT_MODE_HI   7
`define TEC_BIT_IRQ_EN0   0
`define TEC_BIT_IRQ_EN1   1
`define TEC_BIT_FLAG0     4
`define TEC_BIT_FLAG1     5
`define TEC_BIT_PA3       3

// Writable masks of the control registers
`define TEC_CTL0_MASK     8'hDF
`define TEC_CTL1_MASK     8'hF8

// Mode encodings
`define TEC_MODE_EVENT    2'h1
`define TEC_MODE_TIMER    2'h2
`define TEC_MODE_WIDTH    2'h3

// Reset values
`define TEC_CTL_RST       8'h00
`define TEC_CNT_RST       16'h0000
`define TEC_BUF_RST       8'h00

// Stage count giving the system clock divided by four
`define TEC_SYS_DIV4_STG  3'h2

`endif

// ### rtl/tec_pkg.sv
// Types shared by the timer/event counter modules.
// Assumes the constants header is included by each user file.
package tec_pkg;
    typedef logic [1:0] tec_mode_t;
    typedef enum logic {TEC_PW_WAIT, TEC_PW_MEAS} tec_pw_state_t;
endpackage

// ### rtl/tec_counter.sv
// One 16-bit count-up timer/event counter channel with preload.
// Assumes pin_i is already synchronised to clk_i.
`timescale 1ns/1ps
`include "tec_cfg.svh"
module tec_counter #(
    parameter int WIDTH = 16
) (
    // Clock, reset, enable
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               ce_i,
    // Control
    input  wire tec_pkg::tec_mode_t mode_i,
    input  wire logic               edge_sel_i,
    input  wire logic               run_i,
    input  wire logic               hold_i,
    input  wire logic               tick_i,
    input  wire logic               pin_i,
    // Preload write
    input  wire logic               load_i,
    input  wire logic [WIDTH-1:0]   load_val_i,
    // Status
    output logic      [WIDTH-1:0]   count_o,
    output logic                    ovf_o,
    output logic                    done_o
);
    if (WIDTH != 16) begin : g_chk
        $error("tec_counter serves 16-bit counters only");
    end

    logic [WIDTH-1:0]       preload;
    logic                   pin_q;
    tec_pkg::tec_pw_state_t state;

    // Edge and count decode
    wire rise      = pin_i & ~pin_q;
    wire fall      = ~pin_i & pin_q;
    wire cnt_edge  = edge_sel_i ? fall : rise;
    wire start_e   = edge_sel_i ? rise : fall;
    wire stop_e    = edge_sel_i ? fall : rise;
    wire is_evt    = mode_i == `TEC_MODE_EVENT;
    wire is_tmr    = mode_i == `TEC_MODE_TIMER;
    wire is_pw     = mode_i == `TEC_MODE_WIDTH;
    wire meas      = state == tec_pkg::TEC_PW_MEAS;
    wire inc       = run_i & ~hold_i & ((is_evt & cnt_edge)
                   | (is_tmr & tick_i) | (is_pw & meas & tick_i));
    wire at_max    = &count_o;
    wire load_cnt  = load_i & ~run_i;
    wire fin       = run_i & is_pw & meas & stop_e;
    wire [WIDTH-1:0] next_count = load_cnt ? load_val_i
                   : ~inc ? count_o
                   : at_max ? preload : count_o + 1'b1;

    // Counter, preload and measurement state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= `TEC_CNT_RST;
            preload <= `TEC_CNT_RST;
            pin_q   <= 1'b0;
            ovf_o   <= 1'b0;
            done_o  <= 1'b0;
            state   <= tec_pkg::TEC_PW_WAIT;
        end else if (ce_i) begin
            count_o <= next_count;
            if (load_i)
                preload <= load_val_i;
            pin_q   <= pin_i;
            ovf_o   <= inc & at_max & ~load_cnt;
            done_o  <= fin;
            unique case (state)
                tec_pkg::TEC_PW_WAIT:
                    if (run_i & is_pw & start_e)
                        state <= tec_pkg::TEC_PW_MEAS;
                tec_pkg::TEC_PW_MEAS:
                    if (fin | ~run_i | ~is_pw)
                        state <= tec_pkg::TEC_PW_WAIT;
            endcase
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_stop_load;
        load_cnt & ce_i |=> count_o == $past(load_val_i);
    endproperty
    a_stop_load: assert property (p_stop_load)
        else $error("stopped counter did not take preload");

    property p_wrap;
        inc & at_max & ~load_cnt & ce_i |=> count_o == $past(preload);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("overflow did not reload from preload");

    property p_no_run;
        ~run_i & ~load_i & ce_i |=> $stable(count_o);
    endproperty
    a_no_run: assert property (p_no_run)
        else $error("stopped counter moved");
endmodule // tec_counter

// ### rtl/tec_top.sv
// Pair of timer/event counters with prescaler, divider output and
// a classic Wishbone register slave.
// Assumes counter pins and the slow clock arrive asynchronously.
`timescale 1ns/1ps
`include "tec_cfg.svh"
module tec_top #(
    parameter int   WIDTH   = 16,
    parameter int   PSC_W   = 8,
    parameter logic PFD_SRC = 1'b0
) (
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Pins
    input  wire logic        counter0_input_i,
    input  wire logic        counter1_input_i,
    input  wire logic        slow_clk_i,
    // Outputs
    output logic             port_a_bit3_pin_o,
    output logic             wake_o,
    output logic [1:0]       irq_req_o,
    output logic [PSC_W-1:0] pwm_count_o
);
    if (WIDTH != 16 || PSC_W != 8) begin : g_chk
        $error("tec_top serves 16-bit counters and an 8-bit prescaler");
    end

    ////////////////////////////////////////////////////////////////////
    // State

    logic [7:0]       counter0_control;
    logic [7:0]       counter1_control;
    logic [7:0]       buf0;
    logic [7:0]       buf1;
    logic [1:0]       irq_en;
    logic [1:0]       flag;
    logic             pa3;
    logic [1:0]       pfd_tgl;
    logic [2:0]       sync1;
    logic [2:0]       sync2;
    logic             slow_q;
    logic [WIDTH-1:0] count0;
    logic [WIDTH-1:0] count1;
    logic             ovf0;
    logic             ovf1;
    logic             done0;
    logic             done1;

    // Tick when the low stages of the prescaler are all ones
    function automatic logic tick_at(input logic [7:0] p,
                                     input logic [2:0] st);
        logic [7:0] mask;
        mask = 8'(8'h01 << st) - 8'h01;
        return (p & mask) == mask;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    // Two flops on each asynchronous input
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1  <= 3'h0;
            sync2  <= 3'h0;
            slow_q <= 1'b0;
        end else if (ce_i) begin
            sync1  <= {slow_clk_i, counter1_input_i, counter0_input_i};
            sync2  <= sync1;
            slow_q <= sync2[2];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bus decode

    wire [5:0] idx      = adr_i[7:2];
    wire       take     = cyc_i & stb_i & ~ack_o;
    wire       wr       = take & we_i & sel_i[0];
    wire       rd       = take & ~we_i;
    wire [7:0] wd       = dat_i[7:0];
    wire       wr_hi0   = wr & (idx == `TEC_IDX_CNT0_HI);
    wire       wr_lo0   = wr & (idx == `TEC_IDX_CNT0_LO);
    wire       wr_ctl0  = wr & (idx == `TEC_IDX_CNT0_CTL);
    wire       wr_hi1   = wr & (idx == `TEC_IDX_CNT1_HI);
    wire       wr_lo1   = wr & (idx == `TEC_IDX_CNT1_LO);
    wire       wr_ctl1  = wr & (idx == `TEC_IDX_CNT1_CTL);
    wire       wr_irq   = wr & (idx == `TEC_IDX_IRQ);
    wire       wr_pa    = wr & (idx == `TEC_IDX_PORTA);
    wire       rd_hi0   = rd & (idx == `TEC_IDX_CNT0_HI);
    wire       rd_hi1   = rd & (idx == `TEC_IDX_CNT1_HI);

    // Read data selection, unmapped reads give zero
    wire [7:0] rd_byte =
        (idx == `TEC_IDX_CNT0_HI)  ? count0[15:8] :
        (idx == `TEC_IDX_CNT0_LO)  ? buf0 :
        (idx == `TEC_IDX_CNT0_CTL) ? counter0_control :
        (idx == `TEC_IDX_CNT1_HI)  ? count1[15:8] :
        (idx == `TEC_IDX_CNT1_LO)  ? buf1 :
        (idx == `TEC_IDX_CNT1_CTL) ? counter1_control :
        (idx == `TEC_IDX_IRQ)      ? {2'h0, flag, 2'h0, irq_en} :
        (idx == `TEC_IDX_PORTA)    ? {4'h0, pa3, 3'h0} : 8'h00;

    ////////////////////////////////////////////////////////////////////
    // Control field decode

    wire [2:0] psc0     = counter0_control[`TEC_BIT_PSC_HI:`TEC_BIT_PSC_LO];
    wire       run0     = counter0_control[`TEC_BIT_RUN];
    wire       run1     = counter1_control[`TEC_BIT_RUN];
    wire       src1     = counter1_control[`TEC_BIT_SRC];
    wire       slow_rise = sync2[2] & ~slow_q;
    wire       tick0    = tick_at(pwm_count_o, psc0);
    wire       tick1    = src1 ? slow_rise
                        : tick_at(pwm_count_o, `TEC_SYS_DIV4_STG);
    wire       hold0    = rd_hi0;
    wire       hold1    = rd_hi1;
    wire       ovf_sel  = PFD_SRC ? pfd_tgl[1] : pfd_tgl[0];

    // Run bit: software write, else cleared only at width-mode end
    wire [7:0] next_ctl0 = wr_ctl0 ? (wd & `TEC_CTL0_MASK)
        : done0 ? (counter0_control & ~8'h10) : counter0_control;
    wire [7:0] next_ctl1 = wr_ctl1 ? (wd & `TEC_CTL1_MASK)
        : done1 ? (counter1_control & ~8'h10) : counter1_control;

    // Request flags: a new overflow wins over a clear
    wire [1:0] clr_flag  = wr_irq ? wd[`TEC_BIT_FLAG1:`TEC_BIT_FLAG0]
                                  : 2'h0;
    wire [1:0] next_flag = (flag & ~clr_flag) | {ovf1, ovf0};

    ////////////////////////////////////////////////////////////////////
    // Counter channels

    tec_counter #(.WIDTH(WIDTH)) u_ctr0 (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .mode_i     (counter0_control[`TEC_BIT_MODE_HI:`TEC_BIT_MODE_LO]),
        .edge_sel_i (counter0_control[`TEC_BIT_EDGE]),
        .run_i      (run0),
        .hold_i     (hold0),
        .tick_i     (tick0),
        .pin_i      (sync2[0]),
        .load_i     (wr_hi0),
        .load_val_i ({wd, buf0}),
        .count_o    (count0),
        .ovf_o      (ovf0),
        .done_o     (done0)
    );

    tec_counter #(.WIDTH(WIDTH)) u_ctr1 (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .mode_i     (counter1_control[`TEC_BIT_MODE_HI:`TEC_BIT_MODE_LO]),
        .edge_sel_i (counter1_control[`TEC_BIT_EDGE]),
        .run_i      (run1),
        .hold_i     (hold1),
        .tick_i     (tick1),
        .pin_i      (sync2[1]),
        .load_i     (wr_hi1),
        .load_val_i ({wd, buf1}),
        .count_o    (count1),
        .ovf_o      (ovf1),
        .done_o     (done1)
    );

    ////////////////////////////////////////////////////////////////////
    // Bus slave registers

    // Ack one cycle, registered read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_o <= take;
            if (rd)
                dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // Control, enable and port registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            counter0_control <= `TEC_CTL_RST;
            counter1_control <= `TEC_CTL_RST;
            irq_en           <= 2'h0;
            flag             <= 2'h0;
            pa3              <= 1'b0;
        end else if (ce_i) begin
            counter0_control <= next_ctl0;
            counter1_control <= next_ctl1;
            flag             <= next_flag;
            if (wr_irq)
                irq_en <= wd[`TEC_BIT_IRQ_EN1:`TEC_BIT_IRQ_EN0];
            if (wr_pa)
                pa3 <= wd[`TEC_BIT_PA3];
        end
    end

    // Low-byte holding buffers, shared by writes and high reads
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf0 <= `TEC_BUF_RST;
            buf1 <= `TEC_BUF_RST;
        end else if (ce_i) begin
            if (wr_lo0)
                buf0 <= wd;
            else if (rd_hi0)
                buf0 <= count0[7:0];
            if (wr_lo1)
                buf1 <= wd;
            else if (rd_hi1)
                buf1 <= count1[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Prescaler, divider, wake and request outputs

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_count_o       <= '0;
            pfd_tgl           <= 2'h0;
            port_a_bit3_pin_o <= 1'b0;
            wake_o            <= 1'b0;
            irq_req_o         <= 2'h0;
        end else if (ce_i) begin
            pwm_count_o       <= pwm_count_o + 1'b1;
            pfd_tgl           <= pfd_tgl ^ {ovf1, ovf0};
            port_a_bit3_pin_o <= pa3 & ovf_sel;
            wake_o            <= ovf0 | ovf1;
            irq_req_o         <= flag & irq_en;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_take_ctl1;
        wr_ctl1 & ce_i;
    endsequence

    property p_run_write;
        s_take_ctl1 |=> run1 == $past(dat_i[4]);
    endproperty
    a_run_write: assert property (p_run_write)
        else $error("run bit did not follow write");

    property p_pw_clear;
        done0 & ~wr_ctl0 & ce_i |=> ~run0;
    endproperty
    a_pw_clear: assert property (p_pw_clear)
        else $error("width mode left run set");

    property p_run_kept;
        run1 & ~wr_ctl1 & ce_i
            & (counter1_control[7:6] != `TEC_MODE_WIDTH) |=> run1;
    endproperty
    a_run_kept: assert property (p_run_kept)
        else $error("run bit cleared without a write");

    property p_irq_gate;
        ~irq_en[0] & ce_i |=> ~irq_req_o[0];
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("disabled request reached output");

    sequence s_ovf0;
        ovf0 & ce_i;
    endsequence

    property p_flag_set;
        s_ovf0 |=> flag[0];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("overflow did not raise request");

    property p_wake;
        (ovf0 | ovf1) & ce_i |=> wake_o;
    endproperty
    a_wake: assert property (p_wake)
        else $error("overflow did not wake");

    property p_pfd_off;
        ~pa3 & ce_i |=> ~port_a_bit3_pin_o;
    endproperty
    a_pfd_off: assert property (p_pfd_off)
        else $error("divider output active while disabled");

    property p_hi_latch;
        rd_hi0 & ~wr_lo0 & ce_i |=> buf0 == $past(count0[7:0]);
    endproperty
    a_hi_latch: assert property (p_hi_latch)
        else $error("high read did not latch low byte");

    property p_hold;
        hold0 & ce_i |=> count0 == $past(count0);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counter moved during read");

    property p_ack_once;
        ack_o & ce_i |=> ~ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack held for more than one cycle");

    property p_ack_take;
        take & ce_i |=> ack_o;
    endproperty
    a_ack_take: assert property (p_ack_take)
        else $error("request taken but not acknowledged");

    property p_irq_pass;
        flag[0] & irq_en[0] & ce_i |=> irq_req_o[0];
    endproperty
    a_irq_pass: assert property (p_irq_pass)
        else $error("enabled request did not reach output");

    property p_flag_clear;
        wr_irq & wd[`TEC_BIT_FLAG0] & ~ovf0 & ce_i |=> ~flag[0];
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("request flag not cleared by write");

    property p_pfd_toggle;
        ovf0 & ce_i |=> pfd_tgl[0] != $past(pfd_tgl[0]);
    endproperty
    a_pfd_toggle: assert property (p_pfd_toggle)
        else $error("divider did not toggle on overflow");

    property p_psc_count;
        ce_i |=> pwm_count_o == 8'($past(pwm_count_o) + 8'h01);
    endproperty
    a_psc_count: assert property (p_psc_count)
        else $error("prescaler did not advance by one");
endmodule // tec_top

// ### sim/tec_pin_src.sv
// Partner model: pulse source on one external counter pin.
// Assumes the bench raises go_i for one clock per pulse.
`timescale 1ns/1ps
module tec_pin_src (
    // Clock and request
    input  wire logic       clk_i,
    input  wire logic       idle_i,
    input  wire logic       go_i,
    input  wire logic [7:0] width_i,
    // Pin
    output logic            pin_o = 1'b0
);
    logic [7:0] left = 8'h00;

    // Leaves the idle level for width_i+1 cycles, then returns
    always_ff @(posedge clk_i) begin
        if (go_i) begin
            left  <= width_i;
            pin_o <= ~idle_i;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end else begin
            pin_o <= idle_i;
        end
    end
endmodule // tec_pin_src

// ### sim/tec_top_test.sv
// Self-checking bench for the timer/event counter pair.
// Assumes a 1-cycle Wishbone answer and counter 0 on the divider pin.
`timescale 1ns/1ps
`include "tec_cfg.svh"
module tec_top_test;
    localparam logic [5:0] H0 = `TEC_IDX_CNT0_HI;
    localparam logic [5:0] C0 = `TEC_IDX_CNT0_CTL;
    localparam logic [5:0] H1 = `TEC_IDX_CNT1_HI;
    localparam logic [5:0] C1 = `TEC_IDX_CNT1_CTL;
    localparam logic [5:0] IQ = `TEC_IDX_IRQ;
    localparam logic [5:0] PA = `TEC_IDX_PORTA;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, idle, go;
    logic        pin1, pa3, wake_o, ce;
    logic [3:0]  sdiv = 4'h0;
    logic [7:0]  adr_i, width, pwm, rd, hi;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o;
    logic [1:0]  irq_req_o;
    logic [15:0] v;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          seed = 32'h2feaa155;
    int          pre;

    tec_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .counter0_input_i(1'b0), .counter1_input_i(pin1),
        .slow_clk_i(sdiv[3]), .port_a_bit3_pin_o(pa3), .wake_o(wake_o),
        .irq_req_o(irq_req_o), .pwm_count_o(pwm));
    tec_pin_src src_u (.clk_i(clk_i), .idle_i(idle), .go_i(go),
        .width_i(width), .pin_o(pin1));

    ////////////////////////////////////////////////////////////////////
    // Report and comparison
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(string what, logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s: expected %h seen %h", what, e, g);
        end
    endtask
    task automatic near(string what, int e, logic [15:0] g);
        samples_checked++;
        if ($isunknown(g) || int'(g) > e + 2 || int'(g) + 2 < e) begin
            mismatches++;
            $display("wrong value %s: expected %0d seen %0d", what, e, g);
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    // Bus cycle: held until ack is sampled high
    task automatic wb(logic [5:0] idx, logic wr, logic [7:0] d);
        int k;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i} <= {2'b11, wr};
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h0, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        if (ack_o !== 1'b1) begin
            mismatches++;
            tally_and_finish();
        end
        rd = dat_o[7:0];
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask
    // High byte read latches low byte; then low byte read
    task automatic rd_cnt(logic [5:0] h);
        wb(h, 1'b0, 8'h00);
        hi = rd;
        wb(h + 6'h01, 1'b0, 8'h00);
        v = {hi, rd};
    endtask
    // Low byte to buffer, high byte moves both
    task automatic set_pre(logic [5:0] h, logic [15:0] p);
        wb(h + 6'h01, 1'b1, p[7:0]);
        wb(h, 1'b1, p[15:8]);
    endtask
    task automatic wait_wake;
        int k;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wake_o !== 1'b1 && k < 300);
        if (wake_o !== 1'b1) begin
            mismatches++;
            tally_and_finish();
        end
        repeat (4) @(posedge clk_i);
    endtask
    task automatic pulse(logic [7:0] w);
        @(posedge clk_i);
        go    <= 1'b1;
        width <= w;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (w + 12) @(posedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Slow clock: rises once every 16 system clocks
    always @(posedge clk_i) begin
        sdiv <= sdiv + 4'h1;
    end

    // Main sequence
    initial begin
        {rst_i, cyc_i, stb_i, we_i, idle, go} = 6'b100000;
        ce = 1'b1;
        {adr_i, width, dat_i, sel_i} = {16'h0, 32'h0, 4'h1};
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(6'h20, 1'b1, 8'hFF);
        for (int i = 0; i < 5; i++) begin
            wb(i < 4 ? C0 + 6'(3 * (i % 2)) : 6'h20, 1'b0, 8'h00);
            check("reset or unmapped", 16'h0, rd);
        end
        wb(C0, 1'b1, 8'h90);
        wb(C0, 1'b1, 8'hEF);
        wb(C0, 1'b0, 8'h00);
        check("ctl0", 16'hCF, rd);
        wb(C1, 1'b1, 8'hEF);
        wb(C1, 1'b0, 8'h00);
        check("ctl1", 16'hE8, rd);
        wb(C1, 1'b1, 8'h00);
        pre = $random(seed) & 32'h7FFF;
        set_pre(H0, 16'(pre));
        wb(H0 + 6'h01, 1'b1, ~pre[7:0]);
        rd_cnt(H0);
        check("stopped load", 16'(pre), v);
        rd = pwm;
        repeat (10) @(posedge clk_i);
        check("pwm count", 16'(8'(rd + 8'd10)), 16'(pwm));
        ce <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd = pwm;
        repeat (10) @(posedge clk_i);
        check("frozen pwm", 16'(rd), 16'(pwm));
        ce <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wb(C0, 1'b1, 8'h80 | 8'(s));
            set_pre(H0, 16'h0000);
            wb(C0, 1'b1, 8'h90 | 8'(s));
            repeat (64) @(posedge clk_i);
            wb(C0, 1'b1, 8'h80 | 8'(s));
            rd_cnt(H0);
            near("timer ticks", 66 >> s, v);
        end
        wb(C0, 1'b1, 8'h87);
        set_pre(H0, 16'hFFF0);
        wb(C0, 1'b1, 8'h97);
        set_pre(H0, 16'h0000);
        rd_cnt(H0);
        check("running hi", 16'hFF, 16'(v[15:8]));
        wb(C0, 1'b1, 8'h87);
        set_pre(H0, 16'hFFF0);
        wb(IQ, 1'b1, 8'h01);
        wb(PA, 1'b1, 8'h08);
        wb(C0, 1'b1, 8'h90);
        wait_wake();
        check("divider pin", 16'h1, 16'(pa3));
        check("irq request", 16'h1, 16'(irq_req_o[0]));
        wb(C0, 1'b0, 8'h00);
        check("run kept", 16'h90, rd);
        wb(IQ, 1'b0, 8'h00);
        check("flag", 16'h11, rd);
        wait_wake();
        check("divider pin", 16'h0, 16'(pa3));
        wb(PA, 1'b1, 8'h00);
        wait_wake();
        check("gated pin", 16'h0, 16'(pa3));
        wb(IQ, 1'b1, 8'h00);
        repeat (3) @(posedge clk_i);
        check("masked irq", 16'h0, 16'(irq_req_o[0]));
        wb(IQ, 1'b1, 8'h10);
        wb(C0, 1'b1, 8'h80);
        set_pre(H1, 16'(pre));
        wb(C1, 1'b1, 8'h50);
        repeat (5) pulse(8'd6);
        wb(C1, 1'b1, 8'h58);
        repeat (3) pulse(8'd6);
        wb(C1, 1'b1, 8'h40);
        rd_cnt(H1);
        check("event count", 16'(pre + 8), v);
        set_pre(H1, 16'h0000);
        wb(C1, 1'b1, 8'hB0);
        repeat (160) @(posedge clk_i);
        wb(C1, 1'b1, 8'hA0);
        rd_cnt(H1);
        near("slow ticks", 10, v);
        for (int e = 0; e < 2; e++) begin
            idle <= (e == 0);
            repeat (10) @(posedge clk_i);
            set_pre(H1, 16'h0000);
            wb(C1, 1'b1, 8'hD0 | 8'(e << 3));
            pulse(8'd40);
            wb(C1, 1'b0, 8'h00);
            check("run cleared", 16'hC0 | 16'(e << 3), rd);
            rd_cnt(H1);
            near("pulse width", 10, v);
        end
        tally_and_finish();
    end
endmodule // tec_top_test
